/* rtl/tcf_config_regs.sv */
// Register bank for temperature compensation, test, update status and filter configuration
// How it works
// - Cubic temperature compensation from three coefficient registers
// - Temperature in hundredths degree, all ones absent
// - Calibration status bit zero: no wiggling data
// - Illumination power register read/write, in percent
// - Test bit one starts watchdog test; resets zero
// - Update status read-only, resets idle, reports codes
// - Enables bits 0,3,4: median, bilateral, sliding average
// - Enable bit 10 frame averaging; reset 0x28c0
// - Bits 6,7,11 enable wiggle, pattern noise, temperature
// - Bit 13 adds distance offset to output
// - Median iterations low byte; resets to one
// - Bilateral range, spatial widths and iteration fields
// - Sliding window size low byte; resets five
// - Square size bits 0-5; window is square
// - Frame count bits 0-3; resets to two
// - Workaround bit 4 stripe correction; reset 0x0010
// - Workaround bit 5 sensor pinout swap correction
// - Workaround bit 6 stripe correction column eight only
// - Command result clears to zero on read unless a new result loads in that cycle
`timescale 1ns/1ns
module tcf_config_regs
  import tcf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire tcf_req_t host_req,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  input wire logic [15:0] temp_in,
  input wire logic temp_valid,
  input wire logic calib_no_wiggle,
  input wire logic [7:0] update_code,
  input wire logic update_load,
  input wire logic [15:0] cmd_result_in,
  input wire logic cmd_result_load,
  output tcf_filter_cfg_t filter_cfg,
  output logic watchdog_test,
  output logic [15:0] illumination_power,
  output logic [31:0] distance_correction
);
  logic [15:0] coeff_lin_q, coeff_quad_q, coeff_cube_q;
  logic [15:0] temp_q;
  logic calib_q;
  logic [15:0] illum_q;
  logic [15:0] test_q;
  logic unlock_q;
  logic [7:0] upd_q;
  logic [15:0] cmd_result_q;
  logic [15:0] dist_offset_q;
  logic [15:0] img_en_q, median_q, bilat_q, slide_q, window_q, frame_q, work_q;
  logic [15:0] rdata_d;
  logic [31:0] comp_corr;
  logic wr_ok;

  assign wr_ok = host_req.wr && !host_req.rd;

  // Compensation coefficients
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      coeff_lin_q <= TCF_RST_ZERO;
      coeff_quad_q <= TCF_RST_ZERO;
      coeff_cube_q <= TCF_RST_ZERO;
    end
    else if (wr_ok)
    begin
      if (host_req.addr == TCF_ADDR_COEFF_LIN)
        coeff_lin_q <= host_req.wdata;
      if (host_req.addr == TCF_ADDR_COEFF_QUAD)
        coeff_quad_q <= host_req.wdata;
      if (host_req.addr == TCF_ADDR_COEFF_CUBE)
        coeff_cube_q <= host_req.wdata;
    end
  end

  // Temperature sample; all ones whenever the sensor reports nothing
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      temp_q <= TCF_TEMP_NONE;
    else
      temp_q <= temp_valid ? temp_in : TCF_TEMP_NONE;
  end

  // Calibration status follows the nonvolatile_memory content flag
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      calib_q <= 1'b0;
    else
      calib_q <= calib_no_wiggle;
  end

  // Illumination power
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      illum_q <= TCF_RST_ILLUM;
    else if (wr_ok && host_req.addr == TCF_ADDR_ILLUM)
      illum_q <= host_req.wdata;
  end

  // Unlock key arms exactly one test write; any other key value disarms
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      unlock_q <= 1'b0;
    else if (wr_ok && host_req.addr == TCF_ADDR_UNLOCK)
      unlock_q <= (host_req.wdata == TCF_UNLOCK_KEY);
    else if (wr_ok && host_req.addr == TCF_ADDR_TEST)
      unlock_q <= 1'b0;
  end

  // Test configuration; a write without the key is dropped silently
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      test_q <= TCF_RST_ZERO;
    else if (wr_ok && host_req.addr == TCF_ADDR_TEST && unlock_q)
      test_q <= host_req.wdata & TCF_MASK_TEST;
  end

  // Update status driven by the updater, never by the host
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      upd_q <= TCF_UPD_IDLE;
    else if (update_load)
      upd_q <= update_code;
  end

  // Command result; a new result in the reading cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cmd_result_q <= TCF_RST_ZERO;
    else if (cmd_result_load)
      cmd_result_q <= cmd_result_in;
    else if (host_req.rd && host_req.addr == TCF_ADDR_CMD_RESULT)
      cmd_result_q <= TCF_RST_ZERO;
  end

  // Distance offset in millimetres
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      dist_offset_q <= TCF_RST_ZERO;
    else if (wr_ok && host_req.addr == TCF_ADDR_DIST_OFFSET)
      dist_offset_q <= host_req.wdata;
  end

  // Filter configuration registers, undefined bits masked off
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      img_en_q <= TCF_RST_IMG_EN;
      median_q <= TCF_RST_MEDIAN;
      bilat_q <= TCF_RST_BILAT;
      slide_q <= TCF_RST_SLIDE;
      window_q <= TCF_RST_WINDOW;
      frame_q <= TCF_RST_FRAME;
      work_q <= TCF_RST_WORKAROUND;
    end
    else if (wr_ok)
    begin
      if (host_req.addr == TCF_ADDR_IMG_EN)
        img_en_q <= host_req.wdata & TCF_MASK_IMG_EN;
      if (host_req.addr == TCF_ADDR_MEDIAN)
        median_q <= host_req.wdata & TCF_MASK_MEDIAN;
      if (host_req.addr == TCF_ADDR_BILAT)
        bilat_q <= host_req.wdata;
      if (host_req.addr == TCF_ADDR_SLIDE)
        slide_q <= host_req.wdata & TCF_MASK_SLIDE;
      if (host_req.addr == TCF_ADDR_WINDOW)
        window_q <= host_req.wdata & TCF_MASK_WINDOW;
      if (host_req.addr == TCF_ADDR_FRAME)
        frame_q <= host_req.wdata & TCF_MASK_FRAME;
      if (host_req.addr == TCF_ADDR_WORKAROUND)
        work_q <= host_req.wdata & TCF_MASK_WORKAROUND;
    end
  end

  // Pipeline configuration, registered so the outputs leave from flops
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      filter_cfg <= '0;
    else
    begin
      filter_cfg.median_en <= img_en_q[TCF_BIT_MEDIAN];
      filter_cfg.bilateral_en <= img_en_q[TCF_BIT_BILAT];
      filter_cfg.sliding_en <= img_en_q[TCF_BIT_SLIDE];
      filter_cfg.wiggle_comp_en <= img_en_q[TCF_BIT_WIGGLE];
      filter_cfg.fixed_pattern_phase_noise_en <= img_en_q[TCF_BIT_PATTERN_NOISE];
      filter_cfg.frame_avg_en <= img_en_q[TCF_BIT_FRAME];
      filter_cfg.temp_comp_en <= img_en_q[TCF_BIT_TEMPCOMP];
      filter_cfg.offset_en <= img_en_q[TCF_BIT_OFFSET];
      filter_cfg.median_iters <= median_q[7:0];
      filter_cfg.range_width <= bilat_q[5:0];
      filter_cfg.spatial_width <= bilat_q[11:6];
      filter_cfg.bilateral_iters <= bilat_q[15:12];
      filter_cfg.sliding_window <= slide_q[7:0];
      filter_cfg.square_size <= window_q[5:0];
      filter_cfg.window_area <= 12'(window_q[5:0]) * 12'(window_q[5:0]);
      filter_cfg.frame_count <= frame_q[3:0];
      filter_cfg.stripe_en <= work_q[TCF_BIT_STRIPE];
      filter_cfg.pinout_swap_en <= work_q[TCF_BIT_SWAP];
      filter_cfg.stripe_col8_en <= work_q[TCF_BIT_COL8];
    end
  end

  // Watchdog test and illumination outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      watchdog_test <= 1'b0;
      illumination_power <= TCF_RST_ILLUM;
    end
    else
    begin
      watchdog_test <= test_q[TCF_BIT_WDOG];
      illumination_power <= illum_q;
    end
  end

  tcf_temp_comp u_comp (
    .clk(clk),
    .reset_n(reset_n),
    .temp(temp_q),
    .coeff_cube(coeff_cube_q),
    .coeff_quad(coeff_quad_q),
    .coeff_lin(coeff_lin_q),
    .corr(comp_corr)
  );

  // Total distance correction: compensation and fixed offset, each added only when its enable bit is set
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      distance_correction <= '0;
    else
      distance_correction <= (img_en_q[TCF_BIT_TEMPCOMP] ? comp_corr : 32'h0000_0000)
        + (img_en_q[TCF_BIT_OFFSET] ? {{16{dist_offset_q[15]}}, dist_offset_q} : 32'h0000_0000);
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    unique case (host_req.addr)
      TCF_ADDR_UNLOCK: rdata_d = 16'h0000;
      TCF_ADDR_CMD_RESULT: rdata_d = cmd_result_q;
      TCF_ADDR_DIST_OFFSET: rdata_d = dist_offset_q;
      TCF_ADDR_COEFF_LIN: rdata_d = coeff_lin_q;
      TCF_ADDR_COEFF_QUAD: rdata_d = coeff_quad_q;
      TCF_ADDR_COEFF_CUBE: rdata_d = coeff_cube_q;
      TCF_ADDR_TEMP: rdata_d = temp_q;
      TCF_ADDR_CALIB2: rdata_d = {15'h0000, calib_q};
      TCF_ADDR_ILLUM: rdata_d = illum_q;
      TCF_ADDR_TEST: rdata_d = test_q;
      TCF_ADDR_UPD_STATUS: rdata_d = {8'h00, upd_q};
      TCF_ADDR_IMG_EN: rdata_d = img_en_q;
      TCF_ADDR_MEDIAN: rdata_d = median_q;
      TCF_ADDR_BILAT: rdata_d = bilat_q;
      TCF_ADDR_SLIDE: rdata_d = slide_q;
      TCF_ADDR_WINDOW: rdata_d = window_q;
      TCF_ADDR_FRAME: rdata_d = frame_q;
      TCF_ADDR_WORKAROUND: rdata_d = work_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      host_rdata <= 16'h0000;
      host_rvalid <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_req.rd;
      if (host_req.rd)
        host_rdata <= rdata_d;
    end
  end

  property p_temp_none;
    @(posedge clk) disable iff (!reset_n)
    !temp_valid |=> (temp_q == TCF_TEMP_NONE);
  endproperty
  a_temp_none: assert property (p_temp_none) else $error("temperature not all ones without sensor");
  property p_calib_read;
    @(posedge clk) disable iff (!reset_n)
    (host_req.rd && host_req.addr == TCF_ADDR_CALIB2) |=> (host_rdata == {15'h0000, $past(calib_q)});
  endproperty
  a_calib_read: assert property (p_calib_read) else $error("calibration status read wrong");
  property p_illum_write;
    @(posedge clk) disable iff (!reset_n)
    (wr_ok && host_req.addr == TCF_ADDR_ILLUM) |=> ##1 (illumination_power == $past(host_req.wdata, 2));
  endproperty
  a_illum_write: assert property (p_illum_write) else $error("illumination power not written");
  property p_test_locked;
    @(posedge clk) disable iff (!reset_n)
    (wr_ok && host_req.addr == TCF_ADDR_TEST && !unlock_q) |=> $stable(test_q);
  endproperty
  a_test_locked: assert property (p_test_locked) else $error("test config written without unlock key");
  property p_wdog_out;
    @(posedge clk) disable iff (!reset_n)
    test_q[TCF_BIT_WDOG] |=> watchdog_test;
  endproperty
  a_wdog_out: assert property (p_wdog_out) else $error("watchdog test not driven");
  property p_upd_hold;
    @(posedge clk) disable iff (!reset_n)
    !update_load |=> $stable(upd_q);
  endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("update status changed without load");
  sequence s_after_reset;
    !$past(reset_n) && reset_n;
  endsequence
  property p_reset_values;
    @(posedge clk) disable iff (!reset_n)
    s_after_reset |-> (img_en_q == TCF_RST_IMG_EN && median_q == TCF_RST_MEDIAN
      && slide_q == TCF_RST_SLIDE && frame_q == TCF_RST_FRAME && work_q == TCF_RST_WORKAROUND && test_q == 16'h0000);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
  property p_enables_follow;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> (filter_cfg.median_en == $past(img_en_q[0]) && filter_cfg.bilateral_en == $past(img_en_q[3])
      && filter_cfg.sliding_en == $past(img_en_q[4]) && filter_cfg.frame_avg_en == $past(img_en_q[10])
      && filter_cfg.temp_comp_en == $past(img_en_q[11]));
  endproperty
  a_enables_follow: assert property (p_enables_follow) else $error("filter enables do not follow register");
  property p_bilat_fields;
    @(posedge clk) disable iff (!reset_n)
    (wr_ok && host_req.addr == TCF_ADDR_BILAT) |=> ##1 (filter_cfg.bilateral_iters == $past(host_req.wdata[15:12], 2)
      && filter_cfg.spatial_width == $past(host_req.wdata[11:6], 2));
  endproperty
  a_bilat_fields: assert property (p_bilat_fields) else $error("bilateral fields wrong");
  property p_window_area;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> (filter_cfg.window_area == 12'($past(window_q[5:0])) * 12'($past(window_q[5:0])));
  endproperty
  a_window_area: assert property (p_window_area) else $error("window area not square of size");
  property p_result_clear;
    @(posedge clk) disable iff (!reset_n)
    (host_req.rd && host_req.addr == TCF_ADDR_CMD_RESULT && !cmd_result_load)
      |=> (cmd_result_q == 16'h0000 && host_rdata == $past(cmd_result_q));
  endproperty
  a_result_clear: assert property (p_result_clear) else $error("command result not cleared on read");
  property p_reserved_zero;
    @(posedge clk) disable iff (!reset_n)
    ((work_q & ~TCF_MASK_WORKAROUND) == 16'h0000) && ((img_en_q & ~TCF_MASK_IMG_EN) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
endmodule

/* rtl/tcf_pkg.sv */
// Package: register map, reset values, field layout and carrier types of the filter config bank
package tcf_pkg;
  // Register word addresses on the control interface
  localparam logic [15:0] TCF_ADDR_UNLOCK = 16'h0022;
  localparam logic [15:0] TCF_ADDR_CMD_RESULT = 16'h0034;
  localparam logic [15:0] TCF_ADDR_DIST_OFFSET = 16'h00c1;
  localparam logic [15:0] TCF_ADDR_COEFF_LIN = 16'h010a;
  localparam logic [15:0] TCF_ADDR_COEFF_QUAD = 16'h010b;
  localparam logic [15:0] TCF_ADDR_COEFF_CUBE = 16'h010c;
  localparam logic [15:0] TCF_ADDR_TEMP = 16'h010d;
  localparam logic [15:0] TCF_ADDR_CALIB2 = 16'h0118;
  localparam logic [15:0] TCF_ADDR_ILLUM = 16'h0159;
  localparam logic [15:0] TCF_ADDR_TEST = 16'h01c0;
  localparam logic [15:0] TCF_ADDR_UPD_STATUS = 16'h01d1;
  localparam logic [15:0] TCF_ADDR_IMG_EN = 16'h01e0;
  localparam logic [15:0] TCF_ADDR_MEDIAN = 16'h01e1;
  localparam logic [15:0] TCF_ADDR_BILAT = 16'h01e4;
  localparam logic [15:0] TCF_ADDR_SLIDE = 16'h01e5;
  localparam logic [15:0] TCF_ADDR_WINDOW = 16'h01e6;
  localparam logic [15:0] TCF_ADDR_FRAME = 16'h01e7;
  localparam logic [15:0] TCF_ADDR_WORKAROUND = 16'h01e9;
  // Values after reset
  localparam logic [15:0] TCF_RST_ZERO = 16'h0000;
  localparam logic [15:0] TCF_RST_ILLUM = 16'h0064;
  localparam logic [15:0] TCF_RST_IMG_EN = 16'h28c0;
  localparam logic [15:0] TCF_RST_MEDIAN = 16'h0001;
  localparam logic [15:0] TCF_RST_BILAT = 16'h13de;
  localparam logic [15:0] TCF_RST_SLIDE = 16'h0005;
  localparam logic [15:0] TCF_RST_WINDOW = 16'h0003;
  localparam logic [15:0] TCF_RST_FRAME = 16'h0002;
  localparam logic [15:0] TCF_RST_WORKAROUND = 16'h0010;
  // Writable bits of each register; all others read zero
  localparam logic [15:0] TCF_MASK_TEST = 16'h0002;
  localparam logic [15:0] TCF_MASK_IMG_EN = 16'h2cd9;
  localparam logic [15:0] TCF_MASK_MEDIAN = 16'h00ff;
  localparam logic [15:0] TCF_MASK_SLIDE = 16'h00ff;
  localparam logic [15:0] TCF_MASK_WINDOW = 16'h003f;
  localparam logic [15:0] TCF_MASK_FRAME = 16'h000f;
  localparam logic [15:0] TCF_MASK_WORKAROUND = 16'h0070;
  // Special values
  localparam logic [15:0] TCF_UNLOCK_KEY = 16'h5e6b;
  localparam logic [15:0] TCF_TEMP_NONE = 16'hffff;
  // Bit positions
  localparam int TCF_BIT_WDOG = 1;
  localparam int TCF_BIT_MEDIAN = 0;
  localparam int TCF_BIT_BILAT = 3;
  localparam int TCF_BIT_SLIDE = 4;
  localparam int TCF_BIT_WIGGLE = 6;
  localparam int TCF_BIT_PATTERN_NOISE = 7;
  localparam int TCF_BIT_FRAME = 10;
  localparam int TCF_BIT_TEMPCOMP = 11;
  localparam int TCF_BIT_OFFSET = 13;
  localparam int TCF_BIT_STRIPE = 4;
  localparam int TCF_BIT_SWAP = 5;
  localparam int TCF_BIT_COL8 = 6;
  // Compensation scale divisors for cubic, quadratic and linear terms
  localparam longint TCF_DIV_CUBE = 100000;
  localparam longint TCF_DIV_QUAD = 10000;
  localparam longint TCF_DIV_LIN = 1000;
  // Update status codes
  typedef enum logic [7:0] {
    TCF_UPD_IDLE = 8'h00, TCF_UPD_NO_MEM = 8'h03, TCF_UPD_CRC = 8'h06, TCF_UPD_ERASING = 8'h08,
    TCF_UPD_FLASHING = 8'h09, TCF_UPD_ERASE_FAIL = 8'h0b, TCF_UPD_FLASH_FAIL = 8'h0c,
    TCF_UPD_SUCCESS = 8'h0e, TCF_UPD_HDR_CONFLICT = 8'h10, TCF_UPD_WRONG_ID = 8'h12,
    TCF_UPD_INCONSISTENT = 8'h14, TCF_UPD_BUSY = 8'h15, TCF_UPD_PROTOCOL = 8'hff
  } tcf_upd_t;
  // Host register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tcf_req_t;
  // Configuration handed to the image pipeline
  typedef struct packed {
    logic median_en;
    logic bilateral_en;
    logic sliding_en;
    logic wiggle_comp_en;
    logic fixed_pattern_phase_noise_en;
    logic frame_avg_en;
    logic temp_comp_en;
    logic offset_en;
    logic [7:0] median_iters;
    logic [5:0] range_width;
    logic [5:0] spatial_width;
    logic [3:0] bilateral_iters;
    logic [7:0] sliding_window;
    logic [5:0] square_size;
    logic [11:0] window_area;
    logic [3:0] frame_count;
    logic stripe_en;
    logic pinout_swap_en;
    logic stripe_col8_en;
  } tcf_filter_cfg_t;
endpackage

/* rtl/tcf_temp_comp.sv */
// Cubic companion-chip temperature compensation, two pipeline stages
`timescale 1ns/1ns
module tcf_temp_comp
  import tcf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] temp,
  input wire logic [15:0] coeff_cube,
  input wire logic [15:0] coeff_quad,
  input wire logic [15:0] coeff_lin,
  output logic [31:0] corr
);
  logic signed [15:0] x_q;
  logic signed [31:0] x2_q;
  logic signed [15:0] a_q, b_q, c_q;
  logic none_q;
  logic signed [63:0] sum;

  // Stage one: square the temperature, hold coefficients beside it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      x_q <= '0;
      x2_q <= '0;
      a_q <= '0;
      b_q <= '0;
      c_q <= '0;
      none_q <= 1'b1;
    end
    else
    begin
      x_q <= signed'(temp);
      x2_q <= signed'(temp) * signed'(temp);
      a_q <= signed'(coeff_cube);
      b_q <= signed'(coeff_quad);
      c_q <= signed'(coeff_lin);
      none_q <= (temp == TCF_TEMP_NONE);
    end
  end

  // Constant divisors synthesise to fixed dividers; area traded for one-cycle result
  always_comb
  begin
    sum = (64'(a_q) * 64'(x2_q) * 64'(x_q)) / TCF_DIV_CUBE
        + (64'(b_q) * 64'(x2_q)) / TCF_DIV_QUAD
        + (64'(c_q) * 64'(x_q)) / TCF_DIV_LIN;
  end

  // Stage two: no sensor means no correction
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      corr <= '0;
    else
      corr <= none_q ? 32'h0000_0000 : sum[31:0];
  end

  property p_no_sensor_no_corr;
    @(posedge clk) disable iff (!reset_n)
    (temp == TCF_TEMP_NONE) |-> ##2 (corr == 32'h0000_0000);
  endproperty
  a_no_sensor_no_corr: assert property (p_no_sensor_no_corr)
    else $error("correction not zero without sensor");
endmodule

/* tb/tcf_config_regs_bench.sv */
// Self-checking bench for the filter configuration register bank
`timescale 1ns/1ns
module tcf_config_regs_bench
  import tcf_pkg::*;
;
  logic clk, reset_n, temp_valid, calib_no_wiggle, update_load, cmd_result_load, host_rvalid, watchdog_test;
  logic [15:0] temp_in, cmd_result_in, host_rdata, illumination_power, d;
  logic [7:0] update_code;
  logic [31:0] distance_correction;
  tcf_req_t host_req;
  tcf_filter_cfg_t filter_cfg;
  int failures, checks_done;
  logic [15:0] mdl [int];
  logic [15:0] rw_addrs [12] = '{TCF_ADDR_COEFF_LIN, TCF_ADDR_COEFF_QUAD, TCF_ADDR_COEFF_CUBE, TCF_ADDR_ILLUM,
    TCF_ADDR_IMG_EN, TCF_ADDR_MEDIAN, TCF_ADDR_BILAT, TCF_ADDR_SLIDE, TCF_ADDR_WINDOW, TCF_ADDR_FRAME,
    TCF_ADDR_WORKAROUND, TCF_ADDR_DIST_OFFSET};
  logic [7:0] codes [13] = '{8'h00, 8'h03, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h15, 8'hff};
  logic [15:0] ro_addrs [5] = '{16'h0200, TCF_ADDR_TEMP, TCF_ADDR_UPD_STATUS, TCF_ADDR_CALIB2, TCF_ADDR_UNLOCK};

  tcf_config_regs u_dut (.clk(clk), .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .temp_in(temp_in), .temp_valid(temp_valid), .calib_no_wiggle(calib_no_wiggle),
    .update_code(update_code), .update_load(update_load), .cmd_result_in(cmd_result_in),
    .cmd_result_load(cmd_result_load), .filter_cfg(filter_cfg), .watchdog_test(watchdog_test),
    .illumination_power(illumination_power), .distance_correction(distance_correction));
  tcf_host_model u_host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  // 250 MHz clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Writable bits per register; unlisted ones take all 16
  function automatic logic [15:0] msk(input logic [15:0] a);
    case (a)
      TCF_ADDR_TEST: return 16'h0002;
      TCF_ADDR_IMG_EN: return 16'h2cd9;
      TCF_ADDR_MEDIAN, TCF_ADDR_SLIDE: return 16'h00ff;
      TCF_ADDR_WINDOW: return 16'h003f;
      TCF_ADDR_FRAME: return 16'h000f;
      TCF_ADDR_WORKAROUND: return 16'h0070;
      default: return 16'hffff;
    endcase
  endfunction
  function automatic logic [15:0] exp_rd(input logic [15:0] a);
    return mdl.exists(a) ? mdl[a] : 16'h0000;
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a);
    u_host.rd(a, d);
    chk_word({16'h0000, d}, {16'h0000, exp_rd(a)});
  endtask
  task automatic mwr(input logic [15:0] a, input logic [15:0] v);
    u_host.wr(a, v);
    mdl[a] = v & msk(a);
  endtask
  // Expected pipeline configuration rebuilt from the model registers
  task automatic cfg_chk();
    tcf_filter_cfg_t e;
    logic [15:0] i, w, b;
    logic [11:0] s;
    i = mdl[TCF_ADDR_IMG_EN];
    s = 12'(mdl[TCF_ADDR_WINDOW][5:0]);
    w = mdl[TCF_ADDR_WORKAROUND];
    b = mdl[TCF_ADDR_BILAT];
    e = '{i[0], i[3], i[4], i[6], i[7], i[10], i[11], i[13], mdl[TCF_ADDR_MEDIAN][7:0], b[5:0], b[11:6], b[15:12],
      mdl[TCF_ADDR_SLIDE][7:0], mdl[TCF_ADDR_WINDOW][5:0], s * s,
      mdl[TCF_ADDR_FRAME][3:0], w[4], w[5], w[6]};
    checks_done++;
    if (e !== filter_cfg)
    begin
      failures++;
      $display("[FAIL] %0t filter config got %h expected %h", $time, filter_cfg, e);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #200000;
    failures++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    void'($urandom(97519));
    reset_n = 1'b0;
    {temp_valid, calib_no_wiggle, update_load, cmd_result_load} = 4'h0;
    {temp_in, cmd_result_in, update_code} = '0;
    foreach (rw_addrs[k]) mdl[rw_addrs[k]] = 16'h0000;
    mdl[TCF_ADDR_ILLUM] = 16'h0064;
    mdl[TCF_ADDR_IMG_EN] = 16'h28c0;
    mdl[TCF_ADDR_MEDIAN] = 16'h0001;
    mdl[TCF_ADDR_BILAT] = 16'h13de;
    mdl[TCF_ADDR_SLIDE] = 16'h0005;
    mdl[TCF_ADDR_WINDOW] = 16'h0003;
    mdl[TCF_ADDR_FRAME] = 16'h0002;
    mdl[TCF_ADDR_WORKAROUND] = 16'h0010;
    mdl[TCF_ADDR_TEMP] = 16'hffff;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    // Reset values, incl. read-only and absent-sensor temperature
    foreach (rw_addrs[k]) rd_chk(rw_addrs[k]);
    rd_chk(TCF_ADDR_TEST);
    rd_chk(TCF_ADDR_UPD_STATUS);
    rd_chk(TCF_ADDR_TEMP);
    rd_chk(TCF_ADDR_CMD_RESULT);
    cfg_chk();
    chk_word({16'h0000, illumination_power}, 32'h00000064);
    // All ones, all zeros, then random words; undefined bits must stay zero
    for (int r = 0; r < 5; r++)
    begin
      foreach (rw_addrs[k]) mwr(rw_addrs[k], r == 0 ? 16'hffff : r == 1 ? 16'h0000 : 16'($urandom));
      foreach (rw_addrs[k]) rd_chk(rw_addrs[k]);
      cfg_chk();
      chk_word({16'h0000, illumination_power}, {16'h0000, mdl[TCF_ADDR_ILLUM]});
    end
    // Unmapped place, key register and read-only registers ignore writes
    u_host.wr(16'h0200, 16'h1234);
    u_host.wr(TCF_ADDR_TEMP, 16'h1234);
    u_host.wr(TCF_ADDR_UPD_STATUS, 16'h0015);
    u_host.wr(TCF_ADDR_CALIB2, 16'h0001);
    u_host.wr(TCF_ADDR_UNLOCK, 16'h1234);
    foreach (ro_addrs[k]) rd_chk(ro_addrs[k]);
    // Guarded test bit: refused without key, taken with it, key spent after
    u_host.wr(TCF_ADDR_TEST, 16'h0002);
    rd_chk(TCF_ADDR_TEST);
    chk_word({31'h0, watchdog_test}, 32'h0);
    u_host.unlocked_wr(TCF_ADDR_TEST, 16'hffff);
    mdl[TCF_ADDR_TEST] = 16'h0002;
    rd_chk(TCF_ADDR_TEST);
    chk_word({31'h0, watchdog_test}, 32'h1);
    u_host.wr(TCF_ADDR_TEST, 16'h0000);
    rd_chk(TCF_ADDR_TEST);
    // Every update status code
    foreach (codes[k])
    begin
      @(posedge clk);
      #1 {update_code, update_load} = {codes[k], 1'b1};
      @(posedge clk);
      #1 update_load = 1'b0;
      mdl[TCF_ADDR_UPD_STATUS] = {8'h00, codes[k]};
      rd_chk(TCF_ADDR_UPD_STATUS);
    end
    // Calibration flag and live temperature
    @(posedge clk);
    #1 {calib_no_wiggle, temp_valid, temp_in} = {2'b11, 16'($urandom)};
    mdl[TCF_ADDR_CALIB2] = 16'h0001;
    mdl[TCF_ADDR_TEMP] = temp_in;
    repeat (2) @(posedge clk);
    rd_chk(TCF_ADDR_CALIB2);
    rd_chk(TCF_ADDR_TEMP);
    // Command result cleared by its own read
    @(posedge clk);
    #1 {cmd_result_in, cmd_result_load} = {16'($urandom), 1'b1};
    mdl[TCF_ADDR_CMD_RESULT] = cmd_result_in;
    @(posedge clk);
    #1 cmd_result_load = 1'b0;
    rd_chk(TCF_ADDR_CMD_RESULT);
    mdl[TCF_ADDR_CMD_RESULT] = 16'h0000;
    rd_chk(TCF_ADDR_CMD_RESULT);
    // Distance correction: linear term, offset, both, then quadratic term
    mwr(TCF_ADDR_COEFF_CUBE, 16'h0000);
    mwr(TCF_ADDR_COEFF_QUAD, 16'h0000);
    mwr(TCF_ADDR_COEFF_LIN, 16'd1000);
    mwr(TCF_ADDR_DIST_OFFSET, 16'hfffb);
    @(posedge clk);
    #1 temp_in = 16'd1234;
    for (int m = 0; m < 3; m++)
    begin
      mwr(TCF_ADDR_IMG_EN, m == 0 ? 16'h0800 : m == 1 ? 16'h2000 : 16'h2800);
      repeat (8) @(posedge clk);
      chk_word(distance_correction, m == 0 ? 32'd1234 : m == 1 ? 32'hfffffffb : 32'd1229);
    end
    mwr(TCF_ADDR_COEFF_LIN, 16'h0000);
    mwr(TCF_ADDR_COEFF_QUAD, 16'd10000);
    mwr(TCF_ADDR_IMG_EN, 16'h0800);
    @(posedge clk);
    #1 temp_in = 16'd30;
    repeat (8) @(posedge clk);
    chk_word(distance_correction, 32'd900);
    finish_test();
  end
endmodule

/* tb/tcf_host_model.sv */
// Host model: single-word register reads and writes on the request port
`timescale 1ns/1ns
module tcf_host_model
  import tcf_pkg::*;
(
  input wire logic clk,
  output tcf_req_t host_req,
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid
);
  tcf_req_t last_req;
  initial host_req = '0;
  // Idle bus shows inverted last address and data, never a stale copy
  task automatic go_idle();
    last_req = host_req;
    host_req = {2'b00, ~last_req.addr, ~last_req.wdata};
  endtask
  // One write, taken at the next rising edge
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    #1 host_req = {2'b10, addr, data};
    @(posedge clk);
    #1 go_idle();
  endtask
  // One read; answer waited for under a bounded count
  task automatic rd(input logic [15:0] addr, output logic [15:0] data);
    int n;
    @(posedge clk);
    #1 host_req = {2'b01, addr, 16'h0000};
    @(posedge clk);
    #1 go_idle();
    n = 0;
    while (host_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1 n++;
    end
    data = (host_rvalid === 1'b1) ? host_rdata : 16'hxxxx;
  endtask
  // Key first, then the guarded write
  task automatic unlocked_wr(input logic [15:0] addr, input logic [15:0] data);
    wr(TCF_ADDR_UNLOCK, TCF_UNLOCK_KEY);
    wr(addr, data);
  endtask
endmodule
